// File: hw/cache_ctrl_pkg.sv
package cache_ctrl_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] CACHE_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] CACHE_CONTROL_RESET = 8'hE6;

    // ==========================================
    // Field positions
    localparam int BIT_WRITE_EN = 7;
    localparam int BIT_READ_EN = 6;
    localparam int BIT_PREFETCH_EN = 5;
    localparam int BIT_FLUSH = 4;
    localparam int BIT_RETURN_FROM_INTERRUPT_INSTRUCTION = 3;
    localparam int BIT_ISR = 2;
    localparam int BIT_CODE_TABLE_READ_INSTRUCTION = 1;
    localparam int BIT_BLOCK = 0;

    // ==========================================
    // Flash write grouping sizes
    localparam logic [2:0] GROUP_SINGLE = 3'h1;
    localparam logic [2:0] GROUP_CODE = 3'h4;
    localparam logic [2:0] GROUP_SCRATCH = 3'h2;

    // ==========================================
    // Kinds of fetch offered to the cache
    typedef enum logic [1:0] {
        FETCH_NORMAL,
        FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION,
        FETCH_TABLE
    } fetch_kind_t;

    // Fetch presented by the core
    typedef struct packed {
        logic valid;
        fetch_kind_t kind;
        logic in_isr;
        logic hit;
    } fetch_req_t;

    // Controls steering the cache datapath
    typedef struct packed {
        logic fill_write;
        logic read_from_cache;
        logic prefetch_issue;
        logic flush_pulse;
    } cache_ctl_t;

endpackage

// File: hw/fetch_gate.sv
module fetch_gate
    import cache_ctrl_pkg::*;
(
    input fetch_req_t req,
    input wire logic [7:0] ctrl,
    output cache_ctl_t gate
);
    // ==========================================
    // Caching eligibility
    wire kind_ok;
    wire isr_ok;
    wire fill_ok;
    assign kind_ok = (req.kind == FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION) ? ctrl[BIT_RETURN_FROM_INTERRUPT_INSTRUCTION] :
                     (req.kind == FETCH_TABLE) ? ctrl[BIT_CODE_TABLE_READ_INSTRUCTION] :
                     1'b1;
    assign isr_ok = !req.in_isr || ctrl[BIT_ISR];
    assign fill_ok = req.valid && kind_ok && isr_ok;

    assign gate.fill_write = fill_ok && ctrl[BIT_WRITE_EN];
    assign gate.read_from_cache = req.valid && req.hit && ctrl[BIT_READ_EN];
    assign gate.prefetch_issue = req.valid && ctrl[BIT_PREFETCH_EN];
    assign gate.flush_pulse = 1'b0;
endmodule

// File: hw/branch_cache_control.sv
// Operation
// - Write enable bit 7 lets ordinary fetches fill the cache.
// - Write enable clear keeps contents, except flash updates and pushes.
// - Bit 2 set allows interrupt routine instructions to be cached.
// - Bit 1 set allows code table read data to be cached.
// - Read enable clear serves fetches from flash or prefetch only.
// - Prefetch enable clear stops look-ahead flash word reads.
// - Writing one to flush invalidates cache; bit reads zero.
// - Return targets are cached only when bit 3 is set; resets zero.
module branch_cache_control
    import cache_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input fetch_req_t fetch,
    input wire logic flash_scratch,
    output cache_ctl_t ctl,
    output logic [2:0] flash_group
);
    // ==========================================
    // Decode
    wire hit_addr;
    wire wr_ctl;
    wire rd_ctl;
    wire flush_req;
    assign hit_addr = addr == CACHE_CONTROL_ADDR;
    assign wr_ctl = wr && hit_addr;
    assign rd_ctl = rd && hit_addr;
    assign flush_req = wr_ctl && wdata[BIT_FLUSH];

    // ==========================================
    // Control register
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic flush_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] group_r;
    logic [2:0] group_nxt;
    cache_ctl_t gate;

    // ==========================================
    // Helpers
    function automatic logic [7:0] strip_flush(input logic [7:0] v);
        return v & ~(8'h01 << BIT_FLUSH);
    endfunction

    function automatic logic [2:0] group_size(input logic block, input logic scratch);
        if (!block)
        begin
            return GROUP_SINGLE;
        end
        return scratch ? GROUP_SCRATCH : GROUP_CODE;
    endfunction

    localparam logic [7:0] CTRL_RESET_STORED = strip_flush(CACHE_CONTROL_RESET);

    // ==========================================
    // Next values
    assign ctrl_nxt = wr_ctl ? strip_flush(wdata) : ctrl_r;
    assign rdata_nxt = rd_ctl ? ctrl_r : 8'h00;
    assign group_nxt = group_size(ctrl_r[BIT_BLOCK], flash_scratch);

    // ==========================================
    // Registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RESET_STORED;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flush_r <= 1'b0;
        end
        else
        begin
            flush_r <= flush_req;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            group_r <= GROUP_SINGLE;
        end
        else
        begin
            group_r <= group_nxt;
        end
    end

    fetch_gate u_gate (
        .req(fetch),
        .ctrl(ctrl_r),
        .gate(gate)
    );

    assign ctl.fill_write = gate.fill_write;
    assign ctl.read_from_cache = gate.read_from_cache;
    assign ctl.prefetch_issue = gate.prefetch_issue;
    assign ctl.flush_pulse = flush_r;
    assign rdata = rdata_r;
    assign flash_group = group_r;

    // ==========================================
    // Checks
    a_flush_one_cycle: assert property (@(posedge clk) disable iff (rst)
        flush_req |=> ctl.flush_pulse ##1 (!ctl.flush_pulse || $past(flush_req)))
        else $error("flush pulse wrong");
    a_flush_reads_zero: assert property (@(posedge clk) disable iff (rst)
        rd_ctl |=> !rdata[BIT_FLUSH])
        else $error("flush bit read as one");
    a_write_gated: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[BIT_WRITE_EN] |-> !ctl.fill_write)
        else $error("fill while writes disabled");
    a_write_allowed: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_WRITE_EN] && fetch.valid && fetch.kind == FETCH_NORMAL && !fetch.in_isr)
        |-> ctl.fill_write)
        else $error("normal fill blocked");
    a_isr_excluded: assert property (@(posedge clk) disable iff (rst)
        (fetch.in_isr && !ctrl_r[BIT_ISR]) |-> !ctl.fill_write)
        else $error("isr code cached");
    a_table_excluded: assert property (@(posedge clk) disable iff (rst)
        (fetch.kind == FETCH_TABLE && !ctrl_r[BIT_CODE_TABLE_READ_INSTRUCTION]) |-> !ctl.fill_write)
        else $error("table data cached");
    a_read_gated: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[BIT_READ_EN] |-> !ctl.read_from_cache)
        else $error("cache read while disabled");
    a_prefetch_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[BIT_PREFETCH_EN] |-> !ctl.prefetch_issue)
        else $error("prefetch while disabled");
    a_return_from_interrupt_instruction_excluded: assert property (@(posedge clk) disable iff (rst)
        (fetch.kind == FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION && !ctrl_r[BIT_RETURN_FROM_INTERRUPT_INSTRUCTION]) |-> !ctl.fill_write)
        else $error("return target cached");
    a_group_size: assert property (@(posedge clk) disable iff (rst)
        ##1 (flash_group == ($past(ctrl_r[BIT_BLOCK]) ?
        ($past(flash_scratch) ? GROUP_SCRATCH : GROUP_CODE) : GROUP_SINGLE)))
        else $error("flash group size wrong");
    a_flush_needs_write: assert property (@(posedge clk) disable iff (rst)
        ctl.flush_pulse |-> $past(flush_req))
        else $error("flush pulse without write");
    a_flush_not_stored: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[BIT_FLUSH])
        else $error("flush bit stored");
    a_write_stores: assert property (@(posedge clk) disable iff (rst)
        wr_ctl |=> (ctrl_r == ($past(wdata) & ~(8'h01 << BIT_FLUSH))))
        else $error("written byte not stored");
    a_ctrl_holds: assert property (@(posedge clk) disable iff (rst)
        !wr_ctl |=> $stable(ctrl_r))
        else $error("register changed without write");
    a_reset_value: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> (ctrl_r == CTRL_RESET_STORED))
        else $error("register reset value wrong");
    a_read_data: assert property (@(posedge clk) disable iff (rst)
        rd_ctl |=> (rdata == $past(ctrl_r)))
        else $error("read data wrong");
    a_read_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !rd_ctl |=> (rdata == 8'h00))
        else $error("read data outside read cycle");
    a_fill_needs_valid: assert property (@(posedge clk) disable iff (rst)
        !fetch.valid |-> !ctl.fill_write)
        else $error("fill without fetch");
    a_isr_allowed: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_WRITE_EN] && ctrl_r[BIT_ISR] && fetch.valid && fetch.in_isr
        && fetch.kind == FETCH_NORMAL) |-> ctl.fill_write)
        else $error("isr code not cached");
    a_table_allowed: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_WRITE_EN] && ctrl_r[BIT_CODE_TABLE_READ_INSTRUCTION] && fetch.valid && !fetch.in_isr
        && fetch.kind == FETCH_TABLE) |-> ctl.fill_write)
        else $error("table data not cached");
    a_return_from_interrupt_instruction_allowed: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_WRITE_EN] && ctrl_r[BIT_RETURN_FROM_INTERRUPT_INSTRUCTION] && fetch.valid && !fetch.in_isr
        && fetch.kind == FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION) |-> ctl.fill_write)
        else $error("return target not cached");
    a_read_allowed: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_READ_EN] && fetch.valid && fetch.hit) |-> ctl.read_from_cache)
        else $error("cache hit not served");
    a_read_needs_hit: assert property (@(posedge clk) disable iff (rst)
        !(fetch.valid && fetch.hit) |-> !ctl.read_from_cache)
        else $error("cache read without hit");
    a_fill_while_unread: assert property (@(posedge clk) disable iff (rst)
        (!ctrl_r[BIT_READ_EN] && ctrl_r[BIT_WRITE_EN] && fetch.valid && !fetch.in_isr
        && fetch.kind == FETCH_NORMAL) |-> ctl.fill_write)
        else $error("fill stopped by read disable");
    a_prefetch_on: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r[BIT_PREFETCH_EN] && fetch.valid) |-> ctl.prefetch_issue)
        else $error("prefetch not issued");
    a_prefetch_needs_fetch: assert property (@(posedge clk) disable iff (rst)
        !fetch.valid |-> !ctl.prefetch_issue)
        else $error("prefetch without fetch");
    a_group_legal: assert property (@(posedge clk) disable iff (rst)
        (flash_group == GROUP_SINGLE) || (flash_group == GROUP_CODE)
        || (flash_group == GROUP_SCRATCH))
        else $error("flash group size illegal");

    c_flush: cover property (@(posedge clk) disable iff (rst) ctl.flush_pulse);
    c_fill: cover property (@(posedge clk) disable iff (rst) ctl.fill_write);
    c_return_from_interrupt_instruction_fill: cover property (@(posedge clk) disable iff (rst)
        ctl.fill_write && fetch.kind == FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION);
    c_block: cover property (@(posedge clk) disable iff (rst) flash_group == GROUP_CODE);
    c_table_fill: cover property (@(posedge clk) disable iff (rst)
        ctl.fill_write && fetch.kind == FETCH_TABLE);
endmodule

// File: tb/core_model.sv
module core_model
    import cache_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input fetch_req_t cmd,
    output fetch_req_t fetch
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Fetch launched per edge; idle fields keep toggling
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fetch <= '0;
        else if (cmd.valid)
            fetch <= cmd;
        else
            fetch <= {1'b0, ~fetch[3:0]};
    end
endmodule

// File: tb/test_branch_cache_control.sv
module test_branch_cache_control;
    import cache_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, flash_scratch = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0] flash_group;
    fetch_req_t cmd = '0, fetch;
    cache_ctl_t ctl;
    int n_fail = 0, checks_done = 0;
    core_model u_core_model (.clk(clk), .rst(rst), .cmd(cmd), .fetch(fetch));
    branch_cache_control u_branch_cache_control (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fetch(fetch),
        .flash_scratch(flash_scratch), .ctl(ctl), .flash_group(flash_group));
    // ====
    // Bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] v);
        @(posedge clk);
        addr <= CACHE_CONTROL_ADDR;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= 8'h00;
        #1 chk(rdata, exp);
    endtask
    task automatic gate(input fetch_kind_t k, input logic isr, input logic [7:0] exp);
        @(posedge clk);
        cmd <= '{1'b1, k, isr, 1'b1};
        @(posedge clk);
        #1 chk({5'h0, ctl.fill_write, ctl.read_from_cache, ctl.prefetch_issue}, exp);
    endtask
    // ====
    // Scenarios
    task automatic t_reset;
        rreg(8'h00, 8'hE6);
        gate(FETCH_NORMAL, 1'b0, 8'h07);
        gate(FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION, 1'b0, 8'h03);
        gate(FETCH_NORMAL, 1'b1, 8'h07);
        gate(FETCH_TABLE, 1'b0, 8'h07);
    endtask
    task automatic t_modes;
        wreg(8'h0E);
        gate(FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION, 1'b0, 8'h00);
        wreg(8'h88);
        gate(FETCH_RETURN_FROM_INTERRUPT_INSTRUCTION, 1'b0, 8'h04);
        gate(FETCH_TABLE, 1'b0, 8'h00);
        gate(FETCH_NORMAL, 1'b1, 8'h00);
        gate(FETCH_NORMAL, 1'b0, 8'h04);
        wreg(8'hC0);
        gate(FETCH_NORMAL, 1'b0, 8'h06);
        @(posedge clk);
        cmd <= '{1'b1, FETCH_NORMAL, 1'b0, 1'b0};
        @(posedge clk);
        #1 chk({5'h0, ctl.fill_write, ctl.read_from_cache, ctl.prefetch_issue}, 8'h04);
        @(posedge clk);
        cmd <= '0;
        repeat (2) @(posedge clk);
        #1 chk({5'h0, ctl.fill_write, ctl.read_from_cache, ctl.prefetch_issue}, 8'h00);
    endtask
    task automatic t_flush;
        wreg(8'h11);
        #1 chk({7'h0, ctl.flush_pulse}, 8'h01);
        @(posedge clk);
        flash_scratch <= 1'b0;
        #1 chk({7'h0, ctl.flush_pulse}, 8'h00);
        chk({5'h0, flash_group}, {5'h0, GROUP_CODE});
        rreg(8'h00, 8'h01);
        rreg(8'h01, 8'h00);
        @(posedge clk);
        flash_scratch <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({5'h0, flash_group}, {5'h0, GROUP_SCRATCH});
        wreg(8'h00);
        @(posedge clk);
        #1 chk({5'h0, flash_group}, {5'h0, GROUP_SINGLE});
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        #50000;
        n_fail++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_flush();
        results();
    end
endmodule
